//--- logic/lin_phy_pkg.sv
// Shared constants and types of the bus transceiver control block.
// Assumes a 50 MHz system clock; the interface, shifter and control core use these names.
`default_nettype none

package lin_phy_pkg;

   // Register addresses seen over the serial port
   localparam logic [3:0] ADDR_BUS_CTRL = 4'h4;
   localparam logic [3:0] ADDR_BUS_STAT = 4'h5;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'hE;
   localparam logic [3:0] ADDR_IRQ_SRC = 4'hF;

   // bus_control_reg fields
   localparam int CTRL_CONF_DIS = 3;
   localparam int CTRL_RX_ONLY = 2;
   localparam int CTRL_SLEW_HI = 1;
   localparam int CTRL_SLEW_LO = 0;
   localparam logic [1:0] SLEW_10K4 = 2'h0;
   localparam logic [1:0] SLEW_20K = 2'h1;
   localparam logic [1:0] SLEW_FAST = 2'h2;
   localparam logic [3:0] CTRL_RESET = 4'h1;

   // bus_status_reg fields
   localparam int STAT_RX_SHORT = 3;
   localparam int STAT_TX_DOM = 2;
   localparam int STAT_OVERTEMP = 1;

   // irq_mask_reg
   localparam int MASK_BUS_BIT = 1;
   localparam logic [3:0] MASK_RESET = 4'h0;

   // Operating mode codes
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_STOP = 2'h1;
   localparam logic [1:0] MODE_SLEEP = 2'h2;
   localparam logic [1:0] MODE_NORMAL_WD = 2'h3;

   // Serial frame shape
   localparam logic [3:0] FRAME_BITS = 4'h8;
   localparam logic [3:0] HALF_BITS = 4'h4;
   localparam logic [3:0] CNT_LIMIT = 4'hF;

   // Timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int STUCK_TIME_MS = 1000;
   localparam int STUCK_CYCLES = STUCK_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int WAKE_FILTER_US = 100;
   localparam int WAKE_CYCLES = WAKE_FILTER_US * 1000 / CLK_PERIOD_NS;
   localparam int DEGLITCH_US = 10;
   localparam int DEGLITCH_CYCLES = DEGLITCH_US * 1000 / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      WAKE_IDLE = 3'h1,
      WAKE_DOM = 3'h2,
      WAKE_ARMED = 3'h4
   } wake_state_type;

   typedef struct packed {
      logic [3:0] addr;
      logic [3:0] data;
   } frame_type;

endpackage : lin_phy_pkg

`default_nettype wire

//--- logic/spi_frame_if.sv
// Carrier between the serial shifter and the control core.
// Assumes both ends run on the same system clock.
`default_nettype none

interface spi_frame_if;
   logic frame_valid;
   logic frame_ready;
   lin_phy_pkg::frame_type frame;
   logic [3:0] rd_addr;
   logic [3:0] rd_status;
   logic [3:0] summary;

   modport shifter (
      output frame_valid,
      output frame,
      output rd_addr,
      input frame_ready,
      input rd_status,
      input summary
   );

   modport core (
      input frame_valid,
      input frame,
      input rd_addr,
      output frame_ready,
      output rd_status,
      output summary
   );
endinterface : spi_frame_if

`default_nettype wire

//--- logic/frame_fifo2.sv
// Small register FIFO with valid/ready on both sides.
// Assumes one clock; storage is flip-flops addressed by index.
`default_nettype none

module frame_fifo2 #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [CW-1:0] count;
   } state_type;

   state_type q;
   state_type d;
   logic push;
   logic pop;

   function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
      ptr_next = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction : ptr_next

   assign in_ready_o = (q.count != CW'(DEPTH));
   assign out_valid_o = (q.count != '0);
   assign out_data_o = q.mem[q.rd_ptr];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wr_ptr] = in_data_i;
         d.wr_ptr = ptr_next(q.wr_ptr);
      end
      if (pop) begin
         d.rd_ptr = ptr_next(q.rd_ptr);
      end
      if (push && !pop) begin
         d.count = q.count + CW'(1);
      end else if (pop && !push) begin
         d.count = q.count - CW'(1);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : frame_fifo2

`default_nettype wire

//--- logic/spi_byte_shifter.sv
// Serial slave shifter: one byte per chip-select frame.
// Assumes serial pins are synchronous to the system clock and that the
// serial clock is several system clocks per phase.
`default_nettype none

module spi_byte_shifter (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic spi_sclk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_n_o,
   spi_frame_if.shifter link
);
   typedef struct packed {
      logic sclk_prev;
      logic cs_n_prev;
      logic [3:0] cnt;
      logic [7:0] rx;
      logic [3:0] addr;
      logic [3:0] summary;
      logic miso;
      logic oe_n;
      logic pend;
      lin_phy_pkg::frame_type frame;
   } state_type;

   state_type q;
   state_type d;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;

   // Summary nibble first, then the addressed register's status
   function automatic logic out_bit(input logic [3:0] cnt, input logic [3:0] summ,
                                    input logic [3:0] stat);
      if (cnt < lin_phy_pkg::HALF_BITS) begin
         out_bit = summ[2'(3 - cnt)];
      end else if (cnt < lin_phy_pkg::FRAME_BITS) begin
         out_bit = stat[2'(7 - cnt)];
      end else begin
         out_bit = 1'b0;
      end
   endfunction : out_bit

   assign sclk_rise = spi_sclk_i & ~q.sclk_prev;
   assign sclk_fall = ~spi_sclk_i & q.sclk_prev;
   assign cs_fall = ~spi_cs_n_i & q.cs_n_prev;
   assign cs_rise = spi_cs_n_i & ~q.cs_n_prev;
   assign spi_miso_o = q.miso;
   assign spi_miso_oe_n_o = q.oe_n;
   assign link.frame_valid = q.pend;
   assign link.frame = q.frame;
   assign link.rd_addr = q.addr;

   always_comb begin
      d = q;
      d.sclk_prev = spi_sclk_i;
      d.cs_n_prev = spi_cs_n_i;
      if (link.frame_ready) begin
         d.pend = 1'b0;
      end
      if (cs_fall) begin
         d.cnt = '0;
         d.oe_n = 1'b0;
         d.summary = link.summary;
         d.miso = link.summary[3];
      end else if (!spi_cs_n_i) begin
         if (sclk_fall) begin
            d.rx = {q.rx[6:0], spi_mosi_i};
            if (q.cnt != lin_phy_pkg::CNT_LIMIT) begin
               d.cnt = q.cnt + 4'h1;
            end
            if (q.cnt == lin_phy_pkg::HALF_BITS - 4'h1) begin
               d.addr = {q.rx[2:0], spi_mosi_i};
            end
         end
         if (sclk_rise) begin
            d.miso = out_bit(q.cnt, q.summary, link.rd_status);
         end
      end
      if (cs_rise) begin
         d.oe_n = 1'b1;
         if (q.cnt == lin_phy_pkg::FRAME_BITS) begin
            d.pend = 1'b1;
            d.frame = q.rx;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         q <= '0;
         q.sclk_prev <= 1'b0;
         q.cs_n_prev <= 1'b1;
         q.oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end
endmodule : spi_byte_shifter

`default_nettype wire

//--- logic/lin_phy_ctrl.sv
// Control and diagnostics of a single-wire bus transceiver plus its serial
// register port. Analog conditions arrive as synchronous level inputs; the
// analog front end and the other device registers sit outside.
`default_nettype none

// Notes on behaviour
// - Two-bit slew field picks 10.4k, 20k or fast; reset gives 20k.
// - Conformance-disable bit resets to 0; writing 1 turns the feature off.
// - Conformance on: deglitched undervoltage with recessive input cuts driver, rxd high.
// - Conformance off: communication runs until supply drops below about 4.6 V.
// - Driver over-temperature shuts transmitter and sets over-temperature flag.
// - Over-temperature shutdown ends when condition gone and transmit input high.
// - Bus fault events raise the interrupt only when the bus mask bit is set.
// - Receive pin short while transmitting sets short flag and shuts transmitter.
// - Short shutdown ends after a receive pin transition with transmit input high.
// - Status read without a present short clears the short flag.
// - Transmit input low for about 1 s shuts transmitter, sets stuck flag.
// - Stuck shutdown ends as soon as the transmit input returns high.
// - Status read with transmit input high clears the stuck flag.
// - Receive-only bit in Normal mode disables the bus driver.
// - Any bus error sets the receive-only bit automatically.
// - Stop mode with receive-only: no wake detection, rxd follows the bus.
// - Stop: driver off; long dominant then rising edge gives a wake interrupt.
// - Sleep: driver off; long dominant then rising edge gives wake reset.
// - One-byte frame: address and control in, summary and status out.
// - Chip select falling starts a frame, drives output, latches the summary nibble.
// - Output changes on rising serial clock, input sampled on falling.
// - A frame counts only with exactly eight sampling edges.
// - Chip select rising commits the write; output floats while deselected.
// - Control register at address 4: conformance, receive-only, slew bits.
// - Status at addresses 4 and 5: short, stuck, over-temperature, zero.
// - Bus summary bit is set whenever any status bit is set.
module lin_phy_ctrl #(
   parameter int STUCK_CYCLES = lin_phy_pkg::STUCK_CYCLES,
   parameter int WAKE_CYCLES = lin_phy_pkg::WAKE_CYCLES,
   parameter int CNT_W = 26,
   parameter int FIFO_DEPTH = 2
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // Serial register port
   input wire logic spi_sclk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_n_o,
   // Operating mode and microcontroller side of the bus
   input wire logic [1:0] mode_i,
   input wire logic txd_i,
   output logic rxd_o,
   input wire logic rxd_fb_i,
   // Analog front end
   input wire logic bus_level_i,
   output logic bus_drive_o,
   output logic [1:0] slew_rate_select_o,
   input wire logic supply_uv_i,
   input wire logic supply_low_i,
   input wire logic overtemp_i,
   input wire logic rxd_short_i,
   // Status of the rest of the device
   input wire logic voltage_summary_status_i,
   input wire logic high_driver_summary_status_i,
   input wire logic low_driver_summary_status_i,
   input wire logic [15:0][3:0] ext_status_i,
   // Frames forwarded to the other device registers
   output logic wr_valid_o,
   input wire logic wr_ready_i,
   output logic [3:0] wr_addr_o,
   output logic [3:0] wr_data_o,
   // Events
   output logic irq_o,
   output logic wake_irq_o,
   output logic wake_reset_o,
   output logic wake_source_o,
   output logic [3:0] bus_status_o
);
   typedef struct packed {
      logic [3:0] bus_control_reg;
      logic [3:0] irq_mask_reg;
      logic rx_pin_short_flag;
      logic tx_stuck_dominant_flag;
      logic bus_overtemp_flag;
      logic ot_off;
      logic short_off;
      logic stuck_off;
      logic short_edge_seen;
      logic rxd_fb_prev;
      logic [CNT_W-1:0] stuck_cnt;
      logic [CNT_W-1:0] degl_cnt;
      logic uv_deglitched;
      lin_phy_pkg::wake_state_type wake_state;
      logic [CNT_W-1:0] wake_cnt;
      logic wake_source;
      logic bus_drive;
      logic rxd;
      logic irq;
      logic wake_irq;
      logic wake_reset;
      logic fwd_valid;
      lin_phy_pkg::frame_type fwd;
   } state_type;

   state_type q;
   state_type d;

   spi_frame_if link ();

   logic fifo_out_valid;
   logic fifo_out_ready;
   lin_phy_pkg::frame_type fifo_out;
   logic [3:0] bus_status_reg;
   logic normal_mode;
   logic stop_mode;
   logic sleep_mode;
   logic rx_only;
   logic uv_cut;
   logic low_cut;
   logic tx_enable;
   logic take;
   logic status_read;
   logic short_set;
   logic stuck_set;
   logic ot_set;
   logic wake_enable;

   function automatic logic is_status_addr(input logic [3:0] a);
      is_status_addr = (a == lin_phy_pkg::ADDR_BUS_CTRL) || (a == lin_phy_pkg::ADDR_BUS_STAT);
   endfunction : is_status_addr

   spi_byte_shifter u_shifter (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .spi_sclk_i(spi_sclk_i),
      .spi_cs_n_i(spi_cs_n_i),
      .spi_mosi_i(spi_mosi_i),
      .spi_miso_o(spi_miso_o),
      .spi_miso_oe_n_o(spi_miso_oe_n_o),
      .link(link.shifter)
   );

   // A stalled forward port backs up into the shifter's pending frame
   frame_fifo2 #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .in_valid_i(link.frame_valid),
      .in_ready_o(link.frame_ready),
      .in_data_i(link.frame),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out)
   );

   assign bus_status_reg = {q.rx_pin_short_flag, q.tx_stuck_dominant_flag,
                            q.bus_overtemp_flag, 1'b0};
   assign link.summary = {voltage_summary_status_i, |bus_status_reg,
                          high_driver_summary_status_i,
                          low_driver_summary_status_i};
   assign link.rd_status = is_status_addr(link.rd_addr) ? bus_status_reg
                           : ext_status_i[link.rd_addr];

   assign normal_mode = (mode_i == lin_phy_pkg::MODE_NORMAL) ||
                        (mode_i == lin_phy_pkg::MODE_NORMAL_WD);
   assign stop_mode = (mode_i == lin_phy_pkg::MODE_STOP);
   assign sleep_mode = (mode_i == lin_phy_pkg::MODE_SLEEP);
   assign rx_only = q.bus_control_reg[lin_phy_pkg::CTRL_RX_ONLY];

   // Only a recessive input is cut; a dominant bit in flight is kept
   assign uv_cut = !q.bus_control_reg[lin_phy_pkg::CTRL_CONF_DIS] &&
                   q.uv_deglitched && txd_i;
   assign low_cut = q.bus_control_reg[lin_phy_pkg::CTRL_CONF_DIS] && supply_low_i;
   assign tx_enable = normal_mode && !rx_only && !q.ot_off && !q.short_off &&
                      !q.stuck_off && !uv_cut && !low_cut;

   assign fifo_out_ready = !q.fwd_valid || wr_ready_i;
   assign take = fifo_out_valid && fifo_out_ready;
   assign status_read = take && is_status_addr(fifo_out.addr);

   assign ot_set = overtemp_i;
   assign short_set = tx_enable && rxd_short_i;
   assign stuck_set = !txd_i && (q.stuck_cnt == CNT_W'(STUCK_CYCLES - 1));
   assign wake_enable = (stop_mode && !rx_only) || sleep_mode;

   assign slew_rate_select_o = q.bus_control_reg[lin_phy_pkg::CTRL_SLEW_HI:
                                                 lin_phy_pkg::CTRL_SLEW_LO];
   assign bus_drive_o = q.bus_drive;
   assign rxd_o = q.rxd;
   assign irq_o = q.irq;
   assign wake_irq_o = q.wake_irq;
   assign wake_reset_o = q.wake_reset;
   assign wake_source_o = q.wake_source;
   assign bus_status_o = bus_status_reg;
   assign wr_valid_o = q.fwd_valid;
   assign wr_addr_o = q.fwd.addr;
   assign wr_data_o = q.fwd.data;

   always_comb begin
      d = q;
      d.irq = 1'b0;
      d.wake_irq = 1'b0;
      d.wake_reset = 1'b0;
      d.rxd_fb_prev = rxd_fb_i;

      // Frame intake: local registers plus forwarding of every frame
      if (wr_ready_i) begin
         d.fwd_valid = 1'b0;
      end
      if (take) begin
         d.fwd_valid = 1'b1;
         d.fwd = fifo_out;
         if (fifo_out.addr == lin_phy_pkg::ADDR_BUS_CTRL) begin
            d.bus_control_reg = fifo_out.data;
         end
         if (fifo_out.addr == lin_phy_pkg::ADDR_IRQ_MASK) begin
            d.irq_mask_reg = fifo_out.data;
         end
         if (fifo_out.addr == lin_phy_pkg::ADDR_IRQ_MASK ||
             fifo_out.addr == lin_phy_pkg::ADDR_IRQ_SRC) begin
            d.wake_source = 1'b0;
         end
      end

      // Supply undervoltage deglitch
      if (supply_uv_i) begin
         if (q.degl_cnt != CNT_W'(lin_phy_pkg::DEGLITCH_CYCLES)) begin
            d.degl_cnt = q.degl_cnt + CNT_W'(1);
         end
         d.uv_deglitched = (q.degl_cnt == CNT_W'(lin_phy_pkg::DEGLITCH_CYCLES));
      end else begin
         d.degl_cnt = '0;
         d.uv_deglitched = 1'b0;
      end

      // Transmit-stuck timer, saturates so the event fires once
      if (txd_i) begin
         d.stuck_cnt = '0;
      end else if (q.stuck_cnt != CNT_W'(STUCK_CYCLES)) begin
         d.stuck_cnt = q.stuck_cnt + CNT_W'(1);
      end

      // Flags: a set in the clearing cycle wins
      if (status_read && !rxd_short_i) begin
         d.rx_pin_short_flag = 1'b0;
      end
      if (short_set) begin
         d.rx_pin_short_flag = 1'b1;
      end
      if (status_read && txd_i) begin
         d.tx_stuck_dominant_flag = 1'b0;
      end
      if (stuck_set) begin
         d.tx_stuck_dominant_flag = 1'b1;
      end
      if (status_read && !overtemp_i) begin
         d.bus_overtemp_flag = 1'b0;
      end
      if (ot_set) begin
         d.bus_overtemp_flag = 1'b1;
      end

      // Shutdown latches and their automatic release
      if (!overtemp_i && txd_i) begin
         d.ot_off = 1'b0;
      end
      if (ot_set) begin
         d.ot_off = 1'b1;
      end
      if (q.short_off && (rxd_fb_i != q.rxd_fb_prev)) begin
         d.short_edge_seen = 1'b1;
      end
      if (q.short_off && q.short_edge_seen && txd_i) begin
         d.short_off = 1'b0;
         d.short_edge_seen = 1'b0;
      end
      if (short_set) begin
         d.short_off = 1'b1;
         d.short_edge_seen = 1'b0;
      end
      if (txd_i) begin
         d.stuck_off = 1'b0;
      end
      if (stuck_set) begin
         d.stuck_off = 1'b1;
      end

      // Error forces receive-only after any software write
      if (short_set || stuck_set || ot_set) begin
         d.bus_control_reg[lin_phy_pkg::CTRL_RX_ONLY] = 1'b1;
      end
      if (q.irq_mask_reg[lin_phy_pkg::MASK_BUS_BIT] &&
          ((short_set && !q.rx_pin_short_flag) ||
           (stuck_set && !q.tx_stuck_dominant_flag) ||
           (ot_set && !q.bus_overtemp_flag))) begin
         d.irq = 1'b1;
      end

      // Bus wake detector
      case (q.wake_state)
         lin_phy_pkg::WAKE_IDLE: begin
            d.wake_cnt = '0;
            if (wake_enable && !bus_level_i) begin
               d.wake_state = lin_phy_pkg::WAKE_DOM;
            end
         end
         lin_phy_pkg::WAKE_DOM: begin
            d.wake_cnt = q.wake_cnt + CNT_W'(1);
            if (!wake_enable || bus_level_i) begin
               d.wake_state = lin_phy_pkg::WAKE_IDLE;
            end else if (q.wake_cnt == CNT_W'(WAKE_CYCLES - 1)) begin
               d.wake_state = lin_phy_pkg::WAKE_ARMED;
            end
         end
         lin_phy_pkg::WAKE_ARMED: begin
            if (!wake_enable) begin
               d.wake_state = lin_phy_pkg::WAKE_IDLE;
            end else if (bus_level_i) begin
               d.wake_state = lin_phy_pkg::WAKE_IDLE;
               d.wake_source = 1'b1;
               d.wake_irq = stop_mode;
               d.wake_reset = sleep_mode;
            end
         end
         default: begin
            d.wake_state = lin_phy_pkg::WAKE_IDLE;
         end
      endcase

      // Pins
      d.bus_drive = tx_enable && !txd_i;
      if (normal_mode) begin
         d.rxd = (uv_cut || low_cut) ? 1'b1 : bus_level_i;
      end else if (stop_mode && rx_only) begin
         d.rxd = bus_level_i;
      end else begin
         d.rxd = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         q <= '0;
         q.bus_control_reg <= lin_phy_pkg::CTRL_RESET;
         q.irq_mask_reg <= lin_phy_pkg::MASK_RESET;
         q.wake_state <= lin_phy_pkg::WAKE_IDLE;
         q.rxd <= 1'b1;
         q.rxd_fb_prev <= 1'b1;
      end else begin
         q <= d;
      end
   end
endmodule : lin_phy_ctrl

`default_nettype wire

//--- tb/spi_master_model.sv
// SPI master model: one byte per chip-select frame.
// Assumes the 50 MHz bench clock; pins change just after its rising edge.
`default_nettype none
module spi_master_model (
   input wire logic clk_sys_i,
   input wire logic miso_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclk_o <= 1'b0;
      cs_n_o <= 1'b1;
      mosi_o <= 1'b1;
   end
   // Four clocks a phase, above the two the shifter needs
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      cs_n_o <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      for (int i = 7; i >= 0; i--) begin
         sclk_o <= 1'b1;
         mosi_o <= tx[i];
         repeat (4) @(posedge clk_sys_i);
         rx[i] = miso_i;
         sclk_o <= 1'b0;
         repeat (4) @(posedge clk_sys_i);
      end
      cs_n_o <= 1'b1;
      mosi_o <= ~tx[0];
      repeat (4) @(posedge clk_sys_i);
   endtask : xfer
endmodule : spi_master_model
`default_nettype wire

//--- tb/lin_phy_ctrl_asserts.sv
// Property checker on the transceiver control block's own ports.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none
module lin_phy_ctrl_asserts (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_miso_oe_n_o,
   input wire logic [1:0] mode_i,
   input wire logic txd_i,
   input wire logic bus_level_i,
   input wire logic overtemp_i,
   input wire logic bus_drive_o,
   input wire logic [1:0] slew_rate_select_o,
   input wire logic wake_irq_o,
   input wire logic wake_reset_o,
   input wire logic [3:0] bus_status_o
);
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);
   AST_SLEW_RESET: assert property ($fell(reset_i) |-> slew_rate_select_o == 2'h1)
      else $error("slew field not 20k after reset");
   AST_CS_DRIVE: assert property ($fell(spi_cs_n_i) |-> ##[1:3] !spi_miso_oe_n_o)
      else $error("serial output not driven after select");
   AST_FLOAT: assert property (spi_cs_n_i [*4] |-> spi_miso_oe_n_o)
      else $error("serial output driven while deselected");
   AST_OVERTEMP: assert property (overtemp_i [*3] |-> !bus_drive_o && bus_status_o[1])
      else $error("over-temperature not handled");
   AST_RECESSIVE: assert property (txd_i [*3] |-> !bus_drive_o)
      else $error("bus driven with recessive input");
   AST_IDLE_MODE: assert property ((mode_i == 2'h1 || mode_i == 2'h2) [*3] |-> !bus_drive_o)
      else $error("driver on in stop or sleep");
   AST_WAKE_IRQ: assert property (wake_irq_o |-> ($past(bus_level_i) && $past(mode_i) == 2'h1) ##1 !wake_irq_o)
      else $error("bad stop wake pulse");
   AST_WAKE_RST: assert property (wake_reset_o |-> ($past(bus_level_i) && $past(mode_i) == 2'h2) ##1 !wake_reset_o)
      else $error("bad sleep wake pulse");
endmodule : lin_phy_ctrl_asserts
bind lin_phy_ctrl lin_phy_ctrl_asserts chk (.clk_sys_i, .reset_i, .spi_cs_n_i, .spi_miso_oe_n_o,
   .mode_i, .txd_i, .bus_level_i, .overtemp_i, .bus_drive_o, .slew_rate_select_o, .wake_irq_o,
   .wake_reset_o, .bus_status_o);
`default_nettype wire

//--- tb/lin_phy_ctrl_test.sv
// Self-checking bench for the transceiver control block.
// Assumes the SPI master model drives the serial port; analog levels are set here.
`default_nettype none
module lin_phy_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i, reset_i, sclk, cs_n, mosi, miso, miso_oe_n, miso_w, txd, rxd, drv;
   logic bus_lvl, ot, wr_valid, wr_ready, irq, wk_irq, wk_rst, sh, wsrc;
   logic [1:0] mode, slew;
   logic [2:0] sums;
   logic [3:0] wr_addr, wr_data, stat;
   logic [15:0][3:0] ext;
   logic [7:0] rx;
   int fail_count = 0, n_compared = 0, n_irq = 0, n_wirq = 0, n_wrst = 0;
   // Released line toggles so a stale bit cannot pass
   assign miso_w = miso_oe_n ? clk_sys_i : miso;
   spi_master_model m (.clk_sys_i, .miso_i(miso_w), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
   lin_phy_ctrl #(.STUCK_CYCLES(200), .WAKE_CYCLES(20)) uut (.clk_sys_i, .reset_i,
      .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
      .spi_miso_oe_n_o(miso_oe_n), .mode_i(mode), .txd_i(txd), .rxd_o(rxd), .rxd_fb_i(rxd),
      .bus_level_i(bus_lvl), .bus_drive_o(drv), .slew_rate_select_o(slew), .supply_uv_i(1'b0),
      .supply_low_i(1'b0), .overtemp_i(ot), .rxd_short_i(sh),
      .voltage_summary_status_i(sums[2]), .high_driver_summary_status_i(sums[1]),
      .low_driver_summary_status_i(sums[0]), .ext_status_i(ext), .wr_valid_o(wr_valid),
      .wr_ready_i(wr_ready), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .irq_o(irq),
      .wake_irq_o(wk_irq), .wake_reset_o(wk_rst), .wake_source_o(wsrc), .bus_status_o(stat));
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      n_irq += (irq === 1'b1);
      n_wirq += (wk_irq === 1'b1);
      n_wrst += (wk_rst === 1'b1);
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : cyc
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic spi(input logic [7:0] tx);
      m.xfer(tx, rx);
      cyc(4);
   endtask : spi
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   initial begin
      reset_i <= 1'b1;
      mode <= 2'h0;
      txd <= 1'b1;
      bus_lvl <= 1'b1;
      ot <= 1'b0;
      sh <= 1'b0;
      wr_ready <= 1'b1;
      sums <= 3'b101;
      ext <= 64'hC000;
      cyc(12);
      reset_i <= 1'b0;
      cyc(1);
      chk({5'h00, wsrc, slew}, 8'h01);
      spi(8'h50);
      chk(rx, 8'h90);
      sums <= 3'b010;
      spi(8'h30);
      chk(rx, 8'h2C);
      sums <= 3'b101;
      for (int s = 2; s >= 0; s--) begin
         spi({6'h10, s[1:0]});
         chk({6'h00, slew}, {6'h00, s[1:0]});
      end
      txd <= 1'b0;
      spi(8'h44);
      chk({7'h00, drv}, 8'h00);
      spi(8'h40);
      chk({7'h00, drv}, 8'h01);
      txd <= 1'b1;
      spi(8'hE2);
      ot <= 1'b1;
      cyc(4);
      chk({drv, 3'h0, stat}, 8'h02);
      ot <= 1'b0;
      cyc(4);
      txd <= 1'b0;
      cyc(4);
      chk({7'h00, drv}, 8'h00);
      txd <= 1'b1;
      chk(n_irq[7:0], 8'h01);
      spi(8'h50);
      chk(rx, 8'hD2);
      spi(8'h40);
      txd <= 1'b0;
      cyc(4);
      chk({drv, 3'h0, stat}, 8'h80);
      txd <= 1'b1;
      spi(8'hE0);
      txd <= 1'b0;
      cyc(210);
      chk({drv, 3'h0, stat}, 8'h04);
      chk(n_irq[7:0], 8'h01);
      txd <= 1'b1;
      spi(8'h50);
      chk(rx, 8'hD4);
      chk({4'h0, stat}, 8'h00);
      spi(8'h40);
      txd <= 1'b0;
      cyc(4);
      chk({7'h00, drv}, 8'h01);
      sh <= 1'b1;
      cyc(4);
      chk({drv, 3'h0, stat}, 8'h08);
      sh <= 1'b0;
      bus_lvl <= 1'b0;
      cyc(4);
      bus_lvl <= 1'b1;
      txd <= 1'b1;
      spi(8'h40);
      txd <= 1'b0;
      cyc(4);
      chk({7'h00, drv}, 8'h01);
      txd <= 1'b1;
      mode <= 2'h1;
      for (int k = 0; k < 2; k++) begin
         bus_lvl <= 1'b0;
         cyc(30);
         chk({7'h00, rxd}, {7'h00, k == 0});
         bus_lvl <= 1'b1;
         cyc(4);
         chk({wsrc, n_wirq[6:0]}, 8'h81);
         mode <= 2'h0;
         spi(8'h44);
         mode <= (k == 0) ? 2'h1 : 2'h2;
      end
      bus_lvl <= 1'b0;
      cyc(30);
      bus_lvl <= 1'b1;
      cyc(4);
      chk(n_wrst[7:0], 8'h01);
      mode <= 2'h0;
      wr_ready <= 1'b0;
      spi(8'h31);
      spi(8'h32);
      chk({wr_valid, 3'h0, wr_data}, 8'h81);
      wr_ready <= 1'b1;
      cyc(1);
      wr_ready <= 1'b0;
      cyc(4);
      chk({wr_valid, 3'h0, wr_data}, 8'h82);
      stop_test();
   end
   initial begin
      cyc(10000);
      fail_count++;
      stop_test();
   end
endmodule : lin_phy_ctrl_test
`default_nettype wire
